// ---- rtl/exec_pkg.sv ----
/*
 Constants and types for the add, add-with-carry, call and procedure-exit
 execution block. Assumes a 256-byte register file and 16-bit program space.
*/
package exec_pkg;
    // APB register offsets
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_INSN = 8'h04;
    localparam logic [7:0] OFF_PC = 8'h08;
    localparam logic [7:0] OFF_FLAGS = 8'h0C;
    localparam logic [7:0] OFF_STATUS = 8'h10;
    localparam logic [7:0] OFF_RF_ADDR = 8'h14;
    localparam logic [7:0] OFF_RF_DATA = 8'h18;
    localparam logic [7:0] OFF_XM_DATA = 8'h1C;
    localparam logic [7:0] OFF_RP = 8'h20;
    // Control bits
    localparam int CTRL_GO = 0;
    localparam int CTRL_STACK16 = 1;
    // Flag positions in the flag byte
    localparam int FL_C = 7;
    localparam int FL_Z = 6;
    localparam int FL_S = 5;
    localparam int FL_V = 4;
    localparam int FL_D = 3;
    localparam int FL_H = 2;
    // Opcodes
    localparam logic [3:0] OP_ADD_HI = 4'h0;
    localparam logic [3:0] OP_ADC_HI = 4'h1;
    localparam logic [3:0] M_RR_W = 4'h2;
    localparam logic [3:0] M_RIR_W = 4'h3;
    localparam logic [3:0] M_RR = 4'h4;
    localparam logic [3:0] M_RIR = 4'h5;
    localparam logic [3:0] M_RIM = 4'h6;
    localparam logic [3:0] M_IRIM = 4'h7;
    localparam logic [7:0] OP_CALL_DIR = 8'hD6;
    localparam logic [7:0] OP_CALL_IND = 8'hD4;
    localparam logic [7:0] OP_EXIT = 8'hAF;
    localparam logic [3:0] WR_PREFIX = 4'hE;
    localparam logic [7:0] SP_HI_ADDR = 8'hFE;
    localparam logic [7:0] SP_LO_ADDR = 8'hFF;
    // Cycle counts
    localparam logic [4:0] CYC_SHORT = 5'd6;
    localparam logic [4:0] CYC_LONG = 5'd10;
    localparam logic [4:0] CYC_CALL = 5'd20;
    localparam logic [4:0] CYC_EXIT = 5'd14;
    localparam logic [7:0] RP_RESET = 8'h00;
    localparam logic [7:0] FLAGS_RESET = 8'h00;
    localparam logic [15:0] PC_RESET = 16'h0000;

    typedef struct packed {
        logic c;
        logic z;
        logic s;
        logic v;
        logic d;
        logic h;
        logic [1:0] spare;
    } flags_t;

    typedef enum {ST_IDLE, ST_EXEC, ST_WAIT} state_t;
endpackage

// ---- rtl/add_call_exec.sv ----
/*
 Execution block for add, add with carry, call and procedure exit.
 Software loads an instruction word (opcode in bits 7:0, then operand bytes)
 and pulses go; the block updates its own register file, external data
 memory array, flags and program counter, holding busy for the cycle count.
 Assumes an APB master at pclk.
*/
// The register offsets and the APB slave port are this design's own decisions.
// Function
// - Add writes two's complement sum to destination, source untouched.
// - Add with carry also adds the current carry flag.
// - Carry flag set on carry out of bit 7.
// - Zero flag set when the 8-bit result is zero.
// - Sign flag copies result bit 7.
// - Overflow set when like-signed operands give opposite-signed result.
// - Half-carry set on carry out of bit 3.
// - Operand byte with high nibble 1110b names a working register.
// - Opcode 02: working-register add, dst high nibble, src low nibble.
// - Opcode 04: register add, source byte then destination byte.
// - Opcode 15: adc from pointed source, source byte before destination.
// - Opcode 06: immediate add, destination byte then immediate.
// - Opcode 07: immediate add through pointer register.
// - Add with carry uses opcodes 12 to 17, same forms.
// - Opcode D6: direct call, 20 cycles, target high byte first.
// - Opcode D4: indirect call through a register pair.
// - Call drops stack pointer by two, pushes next address, loads target.
// - With 16-bit stack pointer, return address goes to external memory.
// - With 8-bit stack pointer, return address goes to register file.
// - Procedure exit pops return address into the program counter.
// - Indirect call operand with high nibble 1110b selects working pair.
`timescale 1ns/1ns
`default_nettype none
module add_call_exec
    import exec_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Status
    output logic busy
);
    logic [7:0] rf_mem [0:255];
    logic [7:0] xm_mem [0:255];
    logic [31:0] insn_reg;
    logic [15:0] program_counter_reg;
    logic [15:0] next_pc;
    flags_t flags_reg;
    logic [7:0] rp_reg;
    logic stack16_reg;
    logic [7:0] rf_addr_reg;
    logic [15:0] xm_addr_reg;
    logic [4:0] cnt_reg;
    logic illegal_reg;
    state_t state_reg;

    logic wr_en, rd_en, go;
    logic [7:0] opc, b1, b2;
    logic [3:0] mode;
    logic is_add, is_adc, is_call_d, is_call_i, is_exit, legal;

    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & penable & ~pwrite;
    assign pready = 1'b1;
    assign go = wr_en && paddr == OFF_CTRL && pwdata[CTRL_GO] && state_reg == ST_IDLE;
    assign opc = insn_reg[7:0];
    assign b1 = insn_reg[15:8];
    assign b2 = insn_reg[23:16];
    assign mode = opc[3:0];
    assign is_add = opc[7:4] == OP_ADD_HI && mode >= M_RR_W && mode <= M_IRIM;
    assign is_adc = opc[7:4] == OP_ADC_HI && mode >= M_RR_W && mode <= M_IRIM;
    assign is_call_d = opc == OP_CALL_DIR;
    assign is_call_i = opc == OP_CALL_IND;
    assign is_exit = opc == OP_EXIT;
    assign legal = is_add | is_adc | is_call_d | is_call_i | is_exit;
    assign busy = state_reg != ST_IDLE;

    // Working-register expansion of an operand byte
    function automatic logic [7:0] expand(input logic [7:0] b, input logic [7:0] rp);
        expand = (b[7:4] == WR_PREFIX) ? {rp[7:4], b[3:0]} : b;
    endfunction

    function automatic logic [7:0] wreg(input logic [3:0] n, input logic [7:0] rp);
        wreg = {rp[7:4], n};
    endfunction

    // Operand decode
    logic [7:0] dst_addr, src_val, dst_val, pair_addr;
    logic [15:0] target;
    always_comb
    begin
        dst_addr = 8'h00;
        src_val = 8'h00;
        unique case (mode)
            M_RR_W:
            begin
                dst_addr = wreg(b1[7:4], rp_reg);
                src_val = rf_mem[wreg(b1[3:0], rp_reg)];
            end
            M_RIR_W:
            begin
                dst_addr = wreg(b1[7:4], rp_reg);
                src_val = rf_mem[rf_mem[wreg(b1[3:0], rp_reg)]];
            end
            M_RR:
            begin
                dst_addr = expand(b2, rp_reg);
                src_val = rf_mem[expand(b1, rp_reg)];
            end
            M_RIR:
            begin
                dst_addr = expand(b2, rp_reg);
                src_val = rf_mem[rf_mem[expand(b1, rp_reg)]];
            end
            M_RIM:
            begin
                dst_addr = expand(b1, rp_reg);
                src_val = b2;
            end
            M_IRIM:
            begin
                dst_addr = rf_mem[expand(b1, rp_reg)];
                src_val = b2;
            end
            default:
            begin
                dst_addr = 8'h00;
                src_val = 8'h00;
            end
        endcase
        dst_val = rf_mem[dst_addr];
        pair_addr = expand(b1, rp_reg) & 8'hFE;
        target = is_call_d ? {b1, b2} : {rf_mem[pair_addr], rf_mem[pair_addr + 8'h01]};
    end

    // Adder and flags
    logic [4:0] lo_sum;
    logic [8:0] sum;
    logic cin;
    flags_t new_flags;
    always_comb
    begin
        cin = is_adc ? flags_reg.c : 1'b0;
        lo_sum = {1'b0, dst_val[3:0]} + {1'b0, src_val[3:0]} + {4'h0, cin};
        sum = {1'b0, dst_val} + {1'b0, src_val} + {8'h00, cin};
        new_flags = flags_reg;
        new_flags.c = sum[8];
        new_flags.z = sum[7:0] == 8'h00;
        new_flags.s = sum[7];
        new_flags.v = (dst_val[7] == src_val[7]) && (sum[7] != dst_val[7]);
        new_flags.d = 1'b0;
        new_flags.h = lo_sum[4];
    end

    // Stack pointer views
    logic [15:0] sp16, sp16_new;
    logic [7:0] sp8, sp8_new;
    always_comb
    begin
        sp16 = {rf_mem[SP_HI_ADDR], rf_mem[SP_LO_ADDR]};
        sp8 = rf_mem[SP_LO_ADDR];
        sp16_new = sp16 - 16'd2;
        sp8_new = sp8 - 8'd2;
        next_pc = program_counter_reg + (is_call_d ? 16'd3 : 16'd2);
    end

    // Sequencer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state_reg <= ST_IDLE;
            cnt_reg <= 5'd0;
            illegal_reg <= 1'b0;
        end
        else
        begin
            unique case (state_reg)
                ST_IDLE:
                    if (go)
                    begin
                        illegal_reg <= ~legal;
                        if (legal)
                        begin
                            state_reg <= ST_EXEC;
                            if (is_add | is_adc)
                                cnt_reg <= (mode <= M_RIR_W) ? CYC_SHORT : CYC_LONG;
                            else if (is_exit)
                                cnt_reg <= CYC_EXIT;
                            else
                                cnt_reg <= CYC_CALL;
                        end
                    end
                ST_EXEC:
                begin
                    // EXEC is the first counted busy cycle
                    state_reg <= ST_WAIT;
                    cnt_reg <= cnt_reg - 5'd1;
                end
                ST_WAIT:
                begin
                    cnt_reg <= cnt_reg - 5'd1;
                    if (cnt_reg == 5'd1)
                        state_reg <= ST_IDLE;
                end
            endcase
        end
    end

    wire exec_now = state_reg == ST_EXEC;

    // Register file: results, stack pushes/pops, software access
    always_ff @(posedge pclk)
    begin
        if (exec_now && (is_add | is_adc))
            rf_mem[dst_addr] <= sum[7:0];
        else if (exec_now && (is_call_d | is_call_i))
        begin
            if (stack16_reg)
            begin
                rf_mem[SP_HI_ADDR] <= sp16_new[15:8];
                rf_mem[SP_LO_ADDR] <= sp16_new[7:0];
            end
            else
            begin
                rf_mem[SP_LO_ADDR] <= sp8_new;
                rf_mem[sp8_new] <= next_pc[15:8];
                rf_mem[sp8_new + 8'h01] <= next_pc[7:0];
            end
        end
        else if (exec_now && is_exit)
        begin
            if (stack16_reg)
            begin
                rf_mem[SP_HI_ADDR] <= sp16[15:8] + {7'h00, &sp16[7:1]};
                rf_mem[SP_LO_ADDR] <= sp16[7:0] + 8'd2;
            end
            else
                rf_mem[SP_LO_ADDR] <= sp8 + 8'd2;
        end
        else if (wr_en && paddr == OFF_RF_DATA && state_reg == ST_IDLE)
            rf_mem[rf_addr_reg] <= pwdata[7:0];
    end

    // External data memory, low 256 bytes modelled
    always_ff @(posedge pclk)
    begin
        if (exec_now && (is_call_d | is_call_i) && stack16_reg)
        begin
            xm_mem[sp16_new[7:0]] <= next_pc[15:8];
            xm_mem[sp16_new[7:0] + 8'h01] <= next_pc[7:0];
        end
        else if (wr_en && paddr == OFF_XM_DATA && state_reg == ST_IDLE)
            xm_mem[xm_addr_reg[7:0]] <= pwdata[7:0];
    end

    // Program counter and flags
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            program_counter_reg <= PC_RESET;
            flags_reg <= FLAGS_RESET;
        end
        else if (exec_now && (is_add | is_adc))
            flags_reg <= new_flags;
        else if (exec_now && (is_call_d | is_call_i))
            program_counter_reg <= target;
        else if (exec_now && is_exit)
            program_counter_reg <= stack16_reg ?
                {xm_mem[sp16[7:0]], xm_mem[sp16[7:0] + 8'h01]} :
                {rf_mem[sp8], rf_mem[sp8 + 8'h01]};
        else if (wr_en && paddr == OFF_PC && !busy)
            program_counter_reg <= pwdata[15:0];
        else if (wr_en && paddr == OFF_FLAGS && !busy)
            flags_reg <= pwdata[7:0];
    end

    // Software-written setup registers
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            insn_reg <= 32'h0000_0000;
            rp_reg <= RP_RESET;
            stack16_reg <= 1'b0;
            rf_addr_reg <= 8'h00;
            xm_addr_reg <= 16'h0000;
        end
        else if (wr_en && !busy)
        begin
            unique case (paddr)
                OFF_INSN: insn_reg <= pwdata;
                OFF_RP: rp_reg <= pwdata[7:0];
                OFF_CTRL: stack16_reg <= pwdata[CTRL_STACK16];
                OFF_RF_ADDR:
                begin
                    rf_addr_reg <= pwdata[7:0];
                    xm_addr_reg <= pwdata[23:8];
                end
                default: ;
            endcase
        end
    end

    // Read mux; unmapped reads zero with slave error
    always_comb
    begin
        prdata = 32'h0000_0000;
        pslverr = 1'b0;
        if (rd_en)
        begin
            unique case (paddr)
                OFF_CTRL: prdata = {30'h0, stack16_reg, 1'b0};
                OFF_INSN: prdata = insn_reg;
                OFF_PC: prdata = {16'h0000, program_counter_reg};
                OFF_FLAGS: prdata = {24'h000000, flags_reg};
                OFF_STATUS: prdata = {30'h0, illegal_reg, busy};
                OFF_RF_ADDR: prdata = {8'h00, xm_addr_reg, rf_addr_reg};
                OFF_RF_DATA: prdata = {24'h000000, rf_mem[rf_addr_reg]};
                OFF_XM_DATA: prdata = {24'h000000, xm_mem[xm_addr_reg[7:0]]};
                OFF_RP: prdata = {24'h000000, rp_reg};
                default: pslverr = 1'b1;
            endcase
        end
    end

    // Assertions
    a_zero_flag: assert property (@(posedge pclk) disable iff (!presetn)
        exec_now && (is_add | is_adc) |=> flags_reg.z == (rf_mem[$past(dst_addr)] == 8'h00))
        else $error("zero flag wrong");
    a_dflag_clear: assert property (@(posedge pclk) disable iff (!presetn)
        exec_now && (is_add | is_adc) |=> !flags_reg.d)
        else $error("decimal flag not cleared");
    a_sign_flag: assert property (@(posedge pclk) disable iff (!presetn)
        exec_now && (is_add | is_adc) |=> flags_reg.s == rf_mem[$past(dst_addr)][7])
        else $error("sign flag wrong");
    a_call_flags: assert property (@(posedge pclk) disable iff (!presetn)
        exec_now && (is_call_d | is_call_i) |=> $stable(flags_reg))
        else $error("call changed flags");
    a_call_pc: assert property (@(posedge pclk) disable iff (!presetn)
        exec_now && is_call_d |=> program_counter_reg == {$past(b1), $past(b2)})
        else $error("call target wrong");
    sequence s_start_short;
        state_reg == ST_IDLE && go && (is_add | is_adc) && mode <= M_RIR_W;
    endsequence
    a_short_time: assert property (@(posedge pclk) disable iff (!presetn)
        s_start_short |=> busy [*6] ##1 !busy)
        else $error("short add timing wrong");
    a_call_time: assert property (@(posedge pclk) disable iff (!presetn)
        state_reg == ST_IDLE && go && (is_call_d | is_call_i) |=> busy ##19 busy ##1 !busy)
        else $error("call timing wrong");
    a_sp_drop: assert property (@(posedge pclk) disable iff (!presetn)
        exec_now && (is_call_d | is_call_i) && !stack16_reg |=>
        rf_mem[SP_LO_ADDR] == $past(sp8) - 8'd2)
        else $error("stack pointer not dropped");
    a_exit_pop: assert property (@(posedge pclk) disable iff (!presetn)
        exec_now && is_exit && !stack16_reg |=>
        program_counter_reg == {rf_mem[$past(sp8)], rf_mem[$past(sp8) + 8'h01]} &&
        rf_mem[SP_LO_ADDR] == $past(sp8) + 8'd2)
        else $error("exit pop wrong");
    a_push_xmem: assert property (@(posedge pclk) disable iff (!presetn)
        exec_now && (is_call_d | is_call_i) && stack16_reg |=>
        xm_mem[$past(sp16_new[7:0])] == $past(next_pc[15:8]) &&
        xm_mem[$past(sp16_new[7:0]) + 8'h01] == $past(next_pc[7:0]))
        else $error("return address not pushed");
    // Refused opcode must leave the sequencer idle
    a_illegal_idle: assert property (@(posedge pclk) disable iff (!presetn)
        go && !legal |=> !busy && illegal_reg)
        else $error("illegal opcode executed");
endmodule
`default_nettype wire

// ---- tb/apb_host.sv ----
/*
 APB master that stands for host software on the far side of the block.
 Assumes one pclk domain; the bench calls its transfer task.
*/
`timescale 1ns/1ns
`default_nettype none
module apb_host (
    // Clock
    input wire logic pclk,
    // APB master
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end

    // Released address and data lines carry the inverse so a stale value never looks valid
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
        end
        while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask
endmodule
`default_nettype wire

// ---- tb/tb.sv ----
/*
 Self-checking bench for the add, add-with-carry, call and exit block.
 Assumes the block's APB slave and the apb_host model on pclk.
*/
`timescale 1ns/1ns
`default_nettype none
module tb;
    import exec_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    wire logic psel, penable, pwrite, pready, pslverr, busy;
    wire logic [7:0] paddr;
    wire logic [31:0] pwdata, prdata;
    logic [7:0] mem [256];
    logic [7:0] rp = 8'h00;
    int fails = 0;
    int samples_checked = 0;
    int cyc = 0;

    always #10 pclk = ~pclk;

    add_call_exec add_call_exec_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .busy(busy));
    apb_host apb_host_inst (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));

    task automatic end_sim();
        $display("Checks %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            fails++;
            $display("BAD %0t timeout", $time);
            end_sim();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        samples_checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("BAD %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic e;
        apb_host_inst.xfer(1'b1, a, d, q, e);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x,
        input string what);
        logic [31:0] q;
        logic e;
        apb_host_inst.xfer(1'b0, a, 32'h0, q, e);
        check(q & m, x, what);
        check({31'h0, e}, 32'h0, "slave error on mapped read");
    endtask

    task automatic set_reg(input logic [7:0] a, input logic [7:0] v);
        wr(OFF_RF_ADDR, {24'h0, a});
        wr(OFF_RF_DATA, {24'h0, v});
        mem[a] = v;
    endtask

    task automatic chk_reg(input logic [7:0] a, input logic [7:0] v);
        wr(OFF_RF_ADDR, {24'h0, a});
        rdc(OFF_RF_DATA, 32'hFF, {24'h0, v}, "register");
    endtask

    task automatic chk_xm(input logic [15:0] a, input logic [7:0] v);
        wr(OFF_RF_ADDR, {8'h0, a, 8'h00});
        rdc(OFF_XM_DATA, 32'hFF, {24'h0, v}, "stack memory");
    endtask

    // Busy is counted over a window longer than any instruction
    task automatic run(input logic [23:0] insn, input logic [1:0] ctl, input int n);
        int hi;
        hi = 0;
        wr(OFF_INSN, {8'h0, insn});
        wr(OFF_CTRL, {30'h0, ctl});
        repeat (32)
        begin
            #1;
            hi += (busy === 1'b1);
            @(posedge pclk);
        end
        check(32'(hi), 32'(n), "busy cycles");
    endtask

    function automatic logic [7:0] ra(input logic [7:0] b);
        return (b[7:4] == 4'hE) ? {rp[7:4], b[3:0]} : b;
    endfunction

    function automatic logic [15:0] add_ref(input logic [7:0] a, input logic [7:0] b,
        input logic ci);
        logic [8:0] s;
        logic [4:0] l;
        s = {1'b0, a} + {1'b0, b} + {8'h0, ci};
        l = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, ci};
        return {s[8], s[7:0] == 8'h00, s[7], (a[7] == b[7]) && (s[7] != a[7]), 1'b0,
            l[4], 2'b00, s[7:0]};
    endfunction

    task automatic add_op(input logic [7:0] op, input logic [7:0] b1, input logic [7:0] b2,
        input logic [7:0] fl);
        logic [3:0] m;
        logic w;
        logic [7:0] d, s, sv;
        logic [15:0] r;
        m = op[3:0];
        w = m < M_RR;
        s = w ? {rp[7:4], b1[3:0]} : ra(b1);
        sv = (m == M_RIR_W || m == M_RIR) ? mem[mem[s]] : mem[s];
        if (m >= M_RIM)
            sv = b2;
        d = w ? {rp[7:4], b1[7:4]} : ((m < M_RIM) ? ra(b2) : ra(b1));
        if (m == M_IRIM)
            d = mem[d];
        r = add_ref(mem[d], sv, op[4] & fl[FL_C]);
        mem[d] = r[7:0];
        wr(OFF_FLAGS, {24'h0, fl});
        run({b2, b1, op}, 2'b01, w ? 6 : 10);
        chk_reg(d, mem[d]);
        chk_reg(s, mem[s]);
        rdc(OFF_FLAGS, 32'hFC, {24'h0, r[15:8]}, "flags");
    endtask

    initial
    begin
        logic [15:0] p, t, sp;
        logic [31:0] q;
        logic e;
        void'($urandom(59140));
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rdc(OFF_PC, 32'hFFFF, {16'h0, PC_RESET}, "pc after reset");
        rdc(OFF_FLAGS, 32'hFC, {24'h0, FLAGS_RESET}, "flags after reset");
        check({31'h0, pready}, 32'h1, "ready");
        apb_host_inst.xfer(1'b0, 8'h40, 32'h0, q, e);
        check({31'h0, e}, 32'h1, "unmapped error");
        check(q, 32'h0, "unmapped data");
        for (int a = 0; a < 256; a++)
            set_reg(8'(a), 8'($urandom));
        rp = {4'($urandom), 4'h0};
        wr(OFF_RP, {24'h0, rp});
        // Corners: zero with carry and overflow, carry-in ripple, sign overflow
        set_reg(8'h40, 8'h80);
        add_op(8'h06, 8'h40, 8'h80, 8'h00);
        set_reg(8'h41, 8'hFF);
        add_op(8'h16, 8'h41, 8'h00, 8'h80);
        set_reg(8'h42, 8'h7F);
        add_op(8'h06, 8'h42, 8'h01, 8'hFC);
        add_op(8'h15, 8'hE3, 8'h4B, 8'h80);
        for (int i = 0; i < 48; i++)
            add_op({3'b000, 1'(i), 4'(2 + (i / 2) % 6)}, 8'($urandom), 8'($urandom),
                8'($urandom));
        p = 16'($urandom);
        t = 16'($urandom);
        sp = 16'($urandom);
        wr(OFF_PC, {16'h0, p});
        set_reg(SP_HI_ADDR, sp[15:8]);
        set_reg(SP_LO_ADDR, sp[7:0]);
        wr(OFF_FLAGS, 32'hA4);
        run({t[7:0], t[15:8], OP_CALL_DIR}, 2'b11, 20);
        rdc(OFF_PC, 32'hFFFF, {16'h0, t}, "call target");
        p = p + 16'h3;
        sp = sp - 16'h2;
        chk_reg(SP_HI_ADDR, sp[15:8]);
        chk_reg(SP_LO_ADDR, sp[7:0]);
        chk_xm(sp, p[15:8]);
        chk_xm(sp + 16'h1, p[7:0]);
        rdc(OFF_FLAGS, 32'hFC, 32'hA4, "flags kept");
        rp = 8'h30;
        wr(OFF_RP, {24'h0, rp});
        wr(OFF_PC, 32'h1A47);
        set_reg(SP_LO_ADDR, 8'h72);
        set_reg(8'h34, 8'h35);
        set_reg(8'h35, 8'h21);
        run({16'h00E4, OP_CALL_IND}, 2'b01, 20);
        rdc(OFF_PC, 32'hFFFF, 32'h3521, "indirect target");
        chk_reg(SP_LO_ADDR, 8'h70);
        chk_reg(8'h70, 8'h1A);
        chk_reg(8'h71, 8'h49);
        run({16'h0000, OP_EXIT}, 2'b01, 14);
        rdc(OFF_PC, 32'hFFFF, 32'h1A49, "exit pc");
        chk_reg(SP_LO_ADDR, 8'h72);
        run({16'h0000, 8'h08}, 2'b01, 0);
        rdc(OFF_STATUS, 32'h2, 32'h2, "illegal opcode");
        end_sim();
    end
endmodule
`default_nettype wire
